// ### dts_top.sv
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Wrong preclear key sets first-step error flag
// - Wrong clear key sets second-step error flag
// - Limit reached or bad key sets event
// - Error and event flags sticky until reset
// - Status bit shows clear window open
// - Count low reads counter bits 15:0
// - Count high reads counter bits 31:16
// - Limit mirrors return configured time-out count
// - Window mirrors return configured interval value
// - Snapshot captures high half on count read
// - 32-bit fetch counter stops at limit
// - Correct 0x08 after preclear resets counter
// - Deadman event raises processor interrupt request
module dts_top (
   input  wire logic        sys_clk,            // 25 MHz system clock
   input  wire logic        reset_n,            // Async reset, active low
   input  wire logic [7:0]  avs_address,        // Byte address
   input  wire logic        avs_read,           // Read request
   input  wire logic        avs_write,          // Write request
   input  wire logic [31:0] avs_writedata,      // Write data
   input  wire logic [3:0]  avs_byteenable,     // Write byte lanes
   output logic      [31:0] avs_readdata,       // Read data
   output logic             avs_waitrequest,    // Stall, high at rest
   input  wire logic        fetch_strobe,       // Instruction fetched
   input  wire logic        timer_enable,       // Timer switched on
   input  wire logic        preclear_key_wr,    // First key written
   input  wire logic [7:0]  preclear_key_field, // First key value
   input  wire logic        clear_key_wr,       // Second key written
   input  wire logic [7:0]  clear_key_field,    // Second key value
   input  wire logic [15:0] cfg_limit_low,      // Time-out count low
   input  wire logic [15:0] cfg_limit_high,     // Time-out count high
   input  wire logic [15:0] cfg_window_low,     // Window interval low
   input  wire logic [15:0] cfg_window_high,    // Window interval high
   output logic             deadman_irq,        // Deadman event request
   output logic             irq                 // Enabled status level
);
   dts_count_if cnt_if ();

   logic                          first_step_error_q;
   logic                          second_step_error_q;
   logic                          deadman_event_flag_q;
   logic                          preclear_armed_q;
   logic                          cfg_loaded_q;
   logic [31:0]                   limit_mirror_value_q;
   logic [31:0]                   window_mirror_value_q;
   logic [15:0]                   snapshot_upper_half_q;
   logic                          win_prev_q;
   logic [dts_pkg::IRQ_BITS-1:0]  irq_stat_q;
   logic [dts_pkg::IRQ_BITS-1:0]  irq_stat_d;
   logic [dts_pkg::IRQ_BITS-1:0]  irq_en_q;
   logic [dts_pkg::IRQ_BITS-1:0]  irq_en_d;
   logic [31:0]                   rd_mux;

   wire                           first_good;
   wire                           first_bad;
   wire                           second_good;
   wire                           second_bad;
   wire                           seq_clear;
   wire                           event_set;
   wire                           rd_take;
   wire                           wr_take;
   wire                           sel_count;
   wire [15:0]                    status_word;
   wire [dts_pkg::IRQ_BITS-1:0]   irq_events;
   wire [dts_pkg::IRQ_BITS-1:0]   irq_clr_mask;
   wire                           deadman_event_d;

   // Clear sequence decode
   assign first_good  = preclear_key_wr
                        & (preclear_key_field == dts_pkg::KEY_PRECLEAR);
   assign first_bad   = preclear_key_wr
                        & (preclear_key_field != dts_pkg::KEY_PRECLEAR);
   // A right second key without an armed first step is a sequence error
   assign second_good = clear_key_wr & preclear_armed_q
                        & (clear_key_field == dts_pkg::KEY_CLEAR);
   assign second_bad  = clear_key_wr & ~second_good;
   assign seq_clear   = second_good;
   assign event_set   = cnt_if.limit_hit | first_bad | second_bad;
   assign deadman_event_d = deadman_event_flag_q | event_set;

   // Counter carrier
   assign cnt_if.fetch  = fetch_strobe;
   // Timer held off until the mirrors load: a zero limit would read as hit
   assign cnt_if.enable = timer_enable & cfg_loaded_q;
   assign cnt_if.clear  = seq_clear;
   assign cnt_if.limit  = limit_mirror_value_q;
   assign cnt_if.window = window_mirror_value_q;

   dts_fetch_counter u_counter (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .cnt     (cnt_if.counter)
   );

   // Bus handshake: first edge latches data, second edge completes
   assign rd_take   = avs_read & avs_waitrequest;
   assign wr_take   = avs_write & ~avs_waitrequest;
   assign sel_count = (avs_address == dts_pkg::OFF_COUNT_LOW) |
                      (avs_address == dts_pkg::OFF_COUNT_HIGH);

   assign status_word = {8'h00,
                         first_step_error_q,
                         second_step_error_q,
                         deadman_event_flag_q,
                         4'h0,
                         cnt_if.window_open};

   always_comb begin
      rd_mux = dts_pkg::RST_WORD;
      if (avs_address == dts_pkg::OFF_STATUS) begin
         rd_mux = {16'h0000, status_word};
      end else if (avs_address == dts_pkg::OFF_COUNT_LOW) begin
         rd_mux = {16'h0000, cnt_if.count[15:0]};
      end else if (avs_address == dts_pkg::OFF_COUNT_HIGH) begin
         rd_mux = {16'h0000, cnt_if.count[31:16]};
      end else if (avs_address == dts_pkg::OFF_LIMIT_LOW) begin
         rd_mux = {16'h0000, limit_mirror_value_q[15:0]};
      end else if (avs_address == dts_pkg::OFF_LIMIT_HIGH) begin
         rd_mux = {16'h0000, limit_mirror_value_q[31:16]};
      end else if (avs_address == dts_pkg::OFF_WINDOW_LOW) begin
         rd_mux = {16'h0000, window_mirror_value_q[15:0]};
      end else if (avs_address == dts_pkg::OFF_WINDOW_HIGH) begin
         rd_mux = {16'h0000, window_mirror_value_q[31:16]};
      end else if (avs_address == dts_pkg::OFF_SNAPSHOT) begin
         rd_mux = {16'h0000, snapshot_upper_half_q};
      end else if (avs_address == dts_pkg::OFF_IRQ_STATUS) begin
         rd_mux = {28'h0000000, irq_stat_q};
      end else if (avs_address == dts_pkg::OFF_IRQ_ENABLE) begin
         rd_mux = {28'h0000000, irq_en_q};
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= dts_pkg::RST_WORD;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : dts_pkg::RST_WORD;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Snapshot matches exactly the data latched for the count read
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         snapshot_upper_half_q <= dts_pkg::RST_HALF;
      end else if (rd_take & sel_count) begin
         snapshot_upper_half_q <= cnt_if.count[31:16];
      end
   end

   // Configuration captured once after reset release, never from a port
   // under reset, so the mirrors are zero until the first edge
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_loaded_q          <= 1'b0;
         limit_mirror_value_q  <= dts_pkg::RST_WORD;
         window_mirror_value_q <= dts_pkg::RST_WORD;
      end else if (!cfg_loaded_q) begin
         cfg_loaded_q          <= 1'b1;
         limit_mirror_value_q  <= {cfg_limit_high, cfg_limit_low};
         window_mirror_value_q <= {cfg_window_high, cfg_window_low};
      end
   end

   // Sticky flags and preclear_armed_q; bus writes never reach them
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         first_step_error_q   <= 1'b0;
         second_step_error_q  <= 1'b0;
         deadman_event_flag_q <= 1'b0;
         preclear_armed_q     <= 1'b0;
      end else begin
         first_step_error_q   <= first_step_error_q | first_bad;
         second_step_error_q  <= second_step_error_q | second_bad;
         deadman_event_flag_q <= deadman_event_d;
         if (seq_clear) begin
            preclear_armed_q <= 1'b0;
         end else if (first_good) begin
            preclear_armed_q <= 1'b1;
         end
      end
   end

   // Interrupt block: sticky status, write-one clear, set beats clear
   assign irq_events[dts_pkg::IRQ_EVENT]      = event_set;
   assign irq_events[dts_pkg::IRQ_FIRST_ERR]  = first_bad;
   assign irq_events[dts_pkg::IRQ_SECOND_ERR] = second_bad;
   assign irq_events[dts_pkg::IRQ_WIN_OPEN]   = cnt_if.window_open
                                                & ~win_prev_q;
   assign irq_clr_mask = (wr_take & avs_byteenable[0]
                          & (avs_address == dts_pkg::OFF_IRQ_CLEAR))
                         ? avs_writedata[dts_pkg::IRQ_BITS-1:0]
                         : dts_pkg::RST_IRQ;

   always_comb begin
      irq_stat_d = (irq_stat_q & ~irq_clr_mask) | irq_events;
      irq_en_d   = irq_en_q;
      if (wr_take & avs_byteenable[0]
          & (avs_address == dts_pkg::OFF_IRQ_ENABLE)) begin
         irq_en_d = avs_writedata[dts_pkg::IRQ_BITS-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_q  <= dts_pkg::RST_IRQ;
         irq_en_q    <= dts_pkg::RST_IRQ;
         win_prev_q  <= 1'b0;
         irq         <= 1'b0;
         deadman_irq <= 1'b0;
      end else begin
         irq_stat_q  <= irq_stat_d;
         irq_en_q    <= irq_en_d;
         win_prev_q  <= cnt_if.window_open;
         irq         <= |(irq_stat_d & irq_en_d);
         deadman_irq <= deadman_event_d;
      end
   end

   // Checks
   sequence s_good_first;
      first_good;
   endsequence

   sequence s_good_second;
      clear_key_wr && (clear_key_field == dts_pkg::KEY_CLEAR);
   endsequence

   sequence s_bus_request;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_count_read;
      avs_read && avs_waitrequest
      && (avs_address == dts_pkg::OFF_COUNT_LOW
          || avs_address == dts_pkg::OFF_COUNT_HIGH);
   endsequence

   // An armed first key survives a gap of 1 to 8 cycles free of second-key writes
   sequence s_key_gap;
      !clear_key_wr throughout (1'b1 ##[0:7] 1'b1);
   endsequence

   chk_first_bad_sets: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (preclear_key_wr && preclear_key_field != dts_pkg::KEY_PRECLEAR)
      |=> first_step_error_q && deadman_event_flag_q)
      else $error("bad first key did not set flags");

   chk_second_bad_sets: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (clear_key_wr && clear_key_field != dts_pkg::KEY_CLEAR)
      |=> second_step_error_q && deadman_event_flag_q)
      else $error("bad second key did not set flags");

   chk_event_on_limit: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (timer_enable && cfg_loaded_q
       && cnt_if.count == limit_mirror_value_q)
      |=> deadman_event_flag_q)
      else $error("limit reached without event flag");

   chk_flags_stay_set: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $past(first_step_error_q) |-> first_step_error_q)
      else $error("sticky flag cleared without reset");

   chk_second_stays_set: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $past(second_step_error_q) |-> second_step_error_q)
      else $error("second-step error flag cleared without reset");

   chk_event_stays_set: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $past(deadman_event_flag_q) |-> deadman_event_flag_q)
      else $error("event flag cleared without reset");

   chk_status_window_bit: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (avs_read && avs_waitrequest && avs_address == dts_pkg::OFF_STATUS)
      |=> avs_readdata[dts_pkg::BIT_WIN_OPEN] == $past(cnt_if.window_open))
      else $error("status window bit wrong");

   chk_status_unused_zero: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(!avs_waitrequest) && $past(avs_address) == dts_pkg::OFF_STATUS
      |-> avs_readdata[4:1] == 4'h0 && avs_readdata[31:8] == 24'h000000)
      else $error("unused status bits not zero");

   chk_count_low_read: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (avs_read && avs_waitrequest
       && avs_address == dts_pkg::OFF_COUNT_LOW)
      |=> avs_readdata == {16'h0000, $past(cnt_if.count[15:0])})
      else $error("count low read wrong");

   chk_count_high_snap: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (avs_read && avs_waitrequest
       && avs_address == dts_pkg::OFF_COUNT_HIGH)
      |=> avs_readdata == {16'h0000, $past(cnt_if.count[31:16])}
          && snapshot_upper_half_q == avs_readdata[15:0])
      else $error("count high read or snapshot wrong");

   chk_snapshot_on_read: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_count_read |=> snapshot_upper_half_q == $past(cnt_if.count[31:16]))
      else $error("snapshot missed the high half at a count read");

   chk_snapshot_holds: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !(avs_read && avs_waitrequest
        && (avs_address == dts_pkg::OFF_COUNT_LOW
            || avs_address == dts_pkg::OFF_COUNT_HIGH))
      |=> $stable(snapshot_upper_half_q))
      else $error("snapshot changed without a count read");

   chk_limit_mirror: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(cfg_loaded_q) |-> limit_mirror_value_q
         == {$past(cfg_limit_high), $past(cfg_limit_low)})
      else $error("limit mirror not loaded");

   chk_window_mirror: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(cfg_loaded_q) |-> window_mirror_value_q
         == {$past(cfg_window_high), $past(cfg_window_low)})
      else $error("window mirror not loaded");

   chk_mirrors_frozen: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      cfg_loaded_q |=> $stable(limit_mirror_value_q)
                       && $stable(window_mirror_value_q))
      else $error("configuration mirror changed after loading");

   chk_clear_sequence: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_good_first ##1 s_key_gap
      ##1 s_good_second |=> cnt_if.count == dts_pkg::RST_WORD)
      else $error("good key pair did not reset counter");

   chk_bus_answer: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_bus_request |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   chk_event_irq: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      event_set |=> deadman_irq [*2])
      else $error("event did not raise interrupt request");
endmodule // dts_top

// ### dts_pkg.sv
package dts_pkg;
   // Register byte offsets, one aligned 32-bit word each
   localparam logic [7:0] OFF_STATUS      = 8'h00;
   localparam logic [7:0] OFF_COUNT_LOW   = 8'h04;
   localparam logic [7:0] OFF_COUNT_HIGH  = 8'h08;
   localparam logic [7:0] OFF_LIMIT_LOW   = 8'h0c;
   localparam logic [7:0] OFF_LIMIT_HIGH  = 8'h10;
   localparam logic [7:0] OFF_WINDOW_LOW  = 8'h14;
   localparam logic [7:0] OFF_WINDOW_HIGH = 8'h18;
   localparam logic [7:0] OFF_SNAPSHOT    = 8'h1c;
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h20;
   localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h24;
   localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h28;

   // Status register field positions
   localparam int BIT_FIRST_ERR  = 7;
   localparam int BIT_SECOND_ERR = 6;
   localparam int BIT_EVENT      = 5;
   localparam int BIT_WIN_OPEN   = 0;

   // Interrupt status / clear / enable field positions
   localparam int IRQ_EVENT      = 0;
   localparam int IRQ_FIRST_ERR  = 1;
   localparam int IRQ_SECOND_ERR = 2;
   localparam int IRQ_WIN_OPEN   = 3;
   localparam int IRQ_BITS       = 4;

   // Clear sequence key patterns
   localparam logic [7:0] KEY_PRECLEAR = 8'h40;
   localparam logic [7:0] KEY_CLEAR    = 8'h08;

   // Reset values and counter step
   localparam logic [31:0]         RST_WORD    = 32'h0000_0000;
   localparam logic [15:0]         RST_HALF    = 16'h0000;
   localparam logic [IRQ_BITS-1:0] RST_IRQ     = 4'h0;
   localparam logic [31:0]         COUNT_STEP  = 32'h0000_0001;
endpackage

// ### dts_count_if.sv
`timescale 1ns/1ps
interface dts_count_if;
   logic        fetch;       // One instruction fetch this cycle
   logic        enable;      // Timer running
   logic        clear;       // Good two-step sequence completed
   logic [31:0] limit;       // Configured time-out count
   logic [31:0] window;      // Configured clear-window interval
   logic [31:0] count;       // Current fetch count
   logic        limit_hit;   // Count equals limit while timer running
   logic        window_open; // Clear window open

   modport counter (
      input  fetch,
      input  enable,
      input  clear,
      input  limit,
      input  window,
      output count,
      output limit_hit,
      output window_open
   );

   modport ctrl (
      output fetch,
      output enable,
      output clear,
      output limit,
      output window,
      input  count,
      input  limit_hit,
      input  window_open
   );
endinterface

// ### dts_fetch_counter.sv
`timescale 1ns/1ps
module dts_fetch_counter (
   input wire logic     sys_clk, // 25 MHz system clock
   input wire logic     reset_n, // Asynchronous reset, active low
   dts_count_if.counter cnt      // Counter side of the carrier
);
   logic [31:0] count_q;
   logic [31:0] count_d;
   wire         at_limit;
   wire         advance;

   assign at_limit = (count_q == cnt.limit);
   assign advance  = cnt.enable & cnt.fetch & ~at_limit;
   assign count_d  = cnt.clear ? dts_pkg::RST_WORD :
                     advance   ? count_q + dts_pkg::COUNT_STEP :
                                 count_q;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= dts_pkg::RST_WORD;
      end else begin
         count_q <= count_d;
      end
   end

   assign cnt.count       = count_q;
   assign cnt.limit_hit   = cnt.enable & at_limit;
   // Window closes again once the limit is reached
   assign cnt.window_open = cnt.enable & (count_q >= cnt.window)
                            & ~at_limit;

   chk_count_stops_limit: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (at_limit && !cnt.clear) |=> $stable(count_q))
      else $error("counter moved past its limit");

   chk_count_steps_fetch: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (cnt.enable && cnt.fetch && !at_limit && !cnt.clear)
      |=> (count_q == $past(count_q) + dts_pkg::COUNT_STEP))
      else $error("fetch did not advance the counter by one");

   chk_window_closed_low: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (count_q < cnt.window) |-> !cnt.window_open)
      else $error("window open below interval");
endmodule // dts_fetch_counter

// ### dts_fetch_model.sv
`timescale 1ns/1ps
module dts_fetch_model (
   input  wire logic       sys_clk,            // System clock
   output logic            fetch_strobe,       // One fetch per high cycle
   output logic            preclear_key_wr,    // First key pulse
   output logic      [7:0] preclear_key_field, // First key value
   output logic            clear_key_wr,       // Second key pulse
   output logic      [7:0] clear_key_field     // Second key value
);
   initial begin
      fetch_strobe = 1'b0;
      preclear_key_wr = 1'b0;
      clear_key_wr = 1'b0;
      preclear_key_field = 8'h00;
      clear_key_field = 8'h00;
   end

   task automatic fetch(input int n);
      @(posedge sys_clk);
      fetch_strobe <= 1'b1;
      repeat (n) @(posedge sys_clk);
      fetch_strobe <= 1'b0;
   endtask

   // Both key lines invert after each pulse, so the line just written drops its key once idle
   task automatic key(input bit second, input logic [7:0] v);
      @(posedge sys_clk);
      if (second) begin
         clear_key_wr <= 1'b1;
         clear_key_field <= v;
      end else begin
         preclear_key_wr <= 1'b1;
         preclear_key_field <= v;
      end
      @(posedge sys_clk);
      preclear_key_wr <= 1'b0;
      clear_key_wr <= 1'b0;
      preclear_key_field <= ~preclear_key_field;
      clear_key_field <= ~clear_key_field;
   endtask
endmodule // dts_fetch_model

// ### deadman_timer_status_readback_tb.sv
`timescale 1ns/1ps
module deadman_timer_status_readback_tb;
   logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address, bad;
   logic [31:0] avs_writedata, avs_readdata, cfg_lim, cfg_win, q;
   logic        fetch_strobe, preclear_key_wr, clear_key_wr, deadman_irq, irq;
   logic [7:0]  preclear_key_field, clear_key_field;
   integer      error_cnt, n_tests, seed;
   longint      m_cnt, m_lim, m_win;
   bit          m_first, m_second, m_event, m_arm;

   dts_top dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .fetch_strobe(fetch_strobe), .timer_enable(1'b1),
      .preclear_key_wr(preclear_key_wr),
      .preclear_key_field(preclear_key_field),
      .clear_key_wr(clear_key_wr), .clear_key_field(clear_key_field),
      .cfg_limit_low(cfg_lim[15:0]), .cfg_limit_high(cfg_lim[31:16]),
      .cfg_window_low(cfg_win[15:0]), .cfg_window_high(cfg_win[31:16]),
      .deadman_irq(deadman_irq), .irq(irq));

   dts_fetch_model pm (
      .sys_clk(sys_clk), .fetch_strobe(fetch_strobe),
      .preclear_key_wr(preclear_key_wr),
      .preclear_key_field(preclear_key_field),
      .clear_key_wr(clear_key_wr), .clear_key_field(clear_key_field));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   task automatic bus(input logic [7:0] a, input bit w, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20) begin
         error_cnt++;
         stop_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(a, 1'b0, 32'h0000_0000);
      chk(nm, e, q);
   endtask

   function automatic logic [31:0] m_stat();
      bit win;
      win = m_cnt >= m_win && m_cnt != m_lim;
      return {24'h0, m_first, m_second, m_event, 4'h0, win};
   endfunction

   task automatic do_fetch(input int n);
      pm.fetch(n);
      m_cnt = (m_cnt + n > m_lim) ? m_lim : m_cnt + n;
      if (m_cnt == m_lim) m_event = 1;
   endtask

   task automatic do_key(input bit second, input logic [7:0] v);
      pm.key(second, v);
      if (!second && v == 8'h40) m_arm = 1;
      else if (!second) {m_first, m_event} = 2'b11;
      else if (v == 8'h08 && m_arm) {m_cnt, m_arm} = 0;
      else {m_second, m_event} = 2'b11;
   endtask

   task automatic do_reset(input logic [31:0] l, input logic [31:0] w);
      reset_n <= 1'b0;
      cfg_lim <= l;
      cfg_win <= w;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      {m_cnt, m_first, m_second, m_event, m_arm} = 0;
      m_lim = l;
      m_win = w;
   endtask

   initial begin
      {reset_n, avs_read, avs_write} = 0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      {cfg_lim, cfg_win} = 0;
      {error_cnt, n_tests} = 0;
      seed = 32'h1f559451;
      do_reset(32'h0001_0010, 32'h0001_0000);
      rd(8'h00, m_stat(), "status");
      rd(8'h04, 32'h0000_0000, "count_low");
      rd(8'h08, 32'h0000_0000, "count_high");
      rd(8'h1c, 32'h0000_0000, "snapshot");
      rd(8'h0c, 32'h0000_0010, "limit_low");
      rd(8'h10, 32'h0000_0001, "limit_high");
      rd(8'h14, 32'h0000_0000, "window_low");
      rd(8'h18, 32'h0000_0001, "window_high");
      do_fetch(65540);
      rd(8'h1c, 32'h0000_0000, "snapshot");
      rd(8'h04, m_cnt[15:0], "count_low");
      rd(8'h1c, m_cnt[31:16], "snapshot");
      rd(8'h08, m_cnt[31:16], "count_high");
      rd(8'h00, m_stat(), "status");
      do_key(1'b0, 8'h40);
      do_key(1'b1, 8'h08);
      rd(8'h04, m_cnt[15:0], "count_low");
      rd(8'h08, m_cnt[31:16], "count_high");
      rd(8'h00, m_stat(), "status");
      $display("test readback done");

      q = 32'd20 + ($random(seed) & 32'hf);
      do_reset(q, q - 32'd8);
      do_fetch(m_lim - 5);
      rd(8'h00, m_stat(), "status");
      chk("deadman_irq", 32'h0, deadman_irq);
      do_fetch(8);
      rd(8'h04, m_cnt[15:0], "count_low");
      rd(8'h00, m_stat(), "status");
      chk("deadman_irq", 32'h1, deadman_irq);
      $display("test limit done");

      do_reset(32'd100, 32'd50);
      chk("deadman_irq", 32'h0, deadman_irq);
      bus(8'h28, 1'b1, 32'h0000_0002);
      rd(8'h28, 32'h0000_0002, "irq_enable");
      bad = 8'($random(seed));
      if (bad == 8'h40) bad = 8'h41;
      do_key(1'b0, bad);
      repeat (4) @(posedge sys_clk);
      chk("irq", 32'h1, irq);
      rd(8'h00, m_stat(), "status");
      rd(8'h20, 32'h0000_0003, "irq_status");
      bus(8'h24, 1'b1, 32'h0000_0002);
      repeat (4) @(posedge sys_clk);
      chk("irq", 32'h0, irq);
      rd(8'h20, 32'h0000_0001, "irq_status");
      bus(8'h00, 1'b1, 32'hffff_ffff);
      rd(8'h00, m_stat(), "status");
      do_key(1'b1, 8'h08);
      rd(8'h00, m_stat(), "status");
      rd(8'h20, 32'h0000_0005, "irq_status");
      do_key(1'b0, 8'h40);
      do_key(1'b1, bad ^ 8'h08 ? bad : 8'h09);
      do_fetch(3);
      do_key(1'b1, 8'h08);
      rd(8'h04, m_cnt[15:0], "count_low");
      rd(8'h00, m_stat(), "status");
      bus(8'h30, 1'b1, 32'hffff_ffff);
      rd(8'h30, 32'h0000_0000, "unmapped");
      $display("test keys done");
      stop_test();
   end
endmodule // deadman_timer_status_readback_tb
